// ===== mif_pkg.sv
// Purpose: Constants and state type for the metering flag and channel-1 offset register block
// Assumes: 20 MHz pclk, APB with 32-bit data, one word per register index
// Notes: Byte address of a register is four times its index
package mif_pkg;

   // Register indices (byte address = index * 4)
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0A;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h0B;
   localparam logic [5:0] IDX_IRQ_STATUS_RC = 6'h0C;
   localparam logic [5:0] IDX_CH1_OFFSET_CTRL = 6'h0D;
   localparam logic [5:0] IDX_VPEAK_THRESHOLD = 6'h10;
   localparam logic [5:0] IDX_IPEAK_THRESHOLD = 6'h11;
   localparam logic [5:0] IDX_ZERO_CROSS_TIMEOUT_FLAG_LIMIT = 6'h12;

   // Flag positions inside the upper status byte (status bit = 8 + position)
   localparam int FLG_VPEAK = 0;
   localparam int FLG_IPEAK = 1;
   localparam int FLG_VA_HALF = 2;
   localparam int FLG_VA_OVF = 3;
   localparam int FLG_ZERO_CROSS_TIMEOUT_FLAG = 4;
   localparam int FLG_PWR_POS = 5;
   localparam int FLG_PWR_NEG = 6;
   // Status bit F is reserved
   localparam logic [7:0] FLAG_MASK = 8'h7F;
   localparam int FLAG_LSB = 8;

   // Offset control field layout
   localparam int OFS_MAG_MSB = 4;
   localparam int OFS_SIGN = 5;
   localparam int OFS_INTEGRATOR = 7;
   localparam logic [7:0] CHANNEL1_OFFSET_INTEGRATOR_CTRL_WMASK = 8'hBF;

   // Values after reset
   localparam logic [7:0] RST_CHANNEL1_OFFSET_INTEGRATOR_CTRL = 8'h00;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [15:0] RST_VPEAK_THR = 16'hFFFF;
   localparam logic [15:0] RST_IPEAK_THR = 16'hFFFF;
   localparam logic [11:0] RST_ZERO_CROSS_TIMEOUT_FLAG_LIMIT = 12'hFFF;

   // Zero-crossing timeout tick: time in microseconds, count derived from clock rate
   localparam int CLK_MHZ = 20;
   localparam int ZERO_CROSS_TIMEOUT_FLAG_TICK_US = 128;
   localparam int ZERO_CROSS_TIMEOUT_FLAG_TICK_CYCLES = ZERO_CROSS_TIMEOUT_FLAG_TICK_US * CLK_MHZ;
   localparam logic [11:0] TICK_LAST = 12'(ZERO_CROSS_TIMEOUT_FLAG_TICK_CYCLES - 1);

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] enable;
      logic [7:0] channel1_offset_integrator_ctrl;
      logic [15:0] vpk_thr;
      logic [15:0] ipk_thr;
      logic [11:0] zx_limit;
      logic [11:0] zx_cnt;
      logic [11:0] div_cnt;
      logic zx_fired;
      logic va_msb;
      logic pwr_neg;
      logic pwr_seen;
      logic [23:0] ch1_out;
      logic [31:0] prdata;
      logic rdy;
      logic slverr;
      logic rc;
   } mif_state_s;

endpackage

// ===== mif_regs.sv
// Purpose: Upper interrupt flags, interrupt enable and channel-1 offset control behind APB
// Assumes: Event inputs come from logic on pclk; no synchronisers needed
// Notes: One wait-free access phase; read data is captured in the setup cycle
//
// What this block does
// - Channel-2 sample above voltage threshold sets bit 8
// - Channel-1 sample above current threshold sets bit 9
// - Apparent energy MSB rising sets bit A
// - Apparent energy overflow sets bit B
// - Missing zero crossing too long sets bit C
// - Power negative to positive sets bit D
// - Power positive to negative sets bit E
// - Offset control is RW at 0x0D except bit 6, which reads zero
// - Low five bits give offset magnitude
// - Bit 5 is sign, one means negative
// - Bit 7 enables integrator, resets to zero
// - Interrupt low when enabled flag is set
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module mif_regs
   import mif_pkg::*;
(
   input wire logic pclk, // APB clock, 20 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write when high
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [23:0] ch1_sample, // Channel-1 waveform sample, signed
   input wire logic ch1_valid, // Channel-1 sample strobe
   input wire logic [23:0] ch2_sample, // Channel-2 waveform sample, signed
   input wire logic ch2_valid, // Channel-2 sample strobe
   input wire logic [23:0] apparent_energy_accumulator, // Apparent energy accumulator
   input wire logic apparent_energy_overflow, // Accumulator overflow pulse
   input wire logic zero_cross, // Line voltage zero-crossing pulse
   input wire logic [23:0] power_sample, // Measured power, signed
   input wire logic power_valid, // Power sample strobe
   output logic [23:0] ch1_corrected, // Channel-1 sample after offset correction
   output logic [4:0] ch1_offset_mag, // Offset correction magnitude
   output logic ch1_offset_neg, // Offset correction is negative
   output logic ch1_integrator_en, // Digital integrator on
   output logic irq_n, // Interrupt pin level, active low
   output logic irq_oe // Interrupt pin drive enable (open drain)
);

   mif_state_s q;
   mif_state_s d;

   logic [5:0] idx;
   logic hit;
   logic setup;
   logic done;
   logic [31:0] rdval;
   logic [7:0] ev;
   logic [7:0] clr;
   logic [23:0] mag1;
   logic [23:0] mag2;
   logic tick;
   logic [23:0] ofs;

   // Peak compare uses magnitude; the most negative code saturates
   function automatic logic [23:0] magnitude(input logic [23:0] s);
      logic [23:0] m;
      m = s[23] ? (~s + 24'h000001) : s;
      if (m[23]) begin
         m = 24'h7FFFFF;
      end
      return m;
   endfunction

   assign idx = paddr[7:2];
   assign setup = psel && !penable;
   assign done = psel && penable && q.rdy;
   assign hit = (paddr[1:0] == 2'h0) && ((idx == IDX_IRQ_ENABLE) || (idx == IDX_IRQ_STATUS)
      || (idx == IDX_IRQ_STATUS_RC) || (idx == IDX_CH1_OFFSET_CTRL)
      || (idx == IDX_VPEAK_THRESHOLD) || (idx == IDX_IPEAK_THRESHOLD)
      || (idx == IDX_ZERO_CROSS_TIMEOUT_FLAG_LIMIT));
   assign mag1 = magnitude(ch1_sample);
   assign mag2 = magnitude(ch2_sample);
   assign tick = (q.div_cnt == TICK_LAST);
   assign ofs = {19'h00000, q.channel1_offset_integrator_ctrl[OFS_MAG_MSB:0]};

   always_comb begin
      rdval = 32'h00000000;
      unique case (idx)
         IDX_IRQ_ENABLE: rdval = {16'h0000, q.enable & FLAG_MASK, 8'h00};
         IDX_IRQ_STATUS, IDX_IRQ_STATUS_RC: rdval = {16'h0000, q.status & FLAG_MASK, 8'h00};
         IDX_CH1_OFFSET_CTRL: rdval = {24'h000000, q.channel1_offset_integrator_ctrl & CHANNEL1_OFFSET_INTEGRATOR_CTRL_WMASK};
         IDX_VPEAK_THRESHOLD: rdval = {16'h0000, q.vpk_thr};
         IDX_IPEAK_THRESHOLD: rdval = {16'h0000, q.ipk_thr};
         IDX_ZERO_CROSS_TIMEOUT_FLAG_LIMIT: rdval = {20'h00000, q.zx_limit};
         default: rdval = 32'h00000000;
      endcase
   end

   always_comb begin
      d = q;
      ev = 8'h00;
      clr = 8'h00;
      ev[FLG_VPEAK] = ch2_valid && (mag2[23:8] > q.vpk_thr);
      ev[FLG_IPEAK] = ch1_valid && (mag1[23:8] > q.ipk_thr);
      ev[FLG_VA_HALF] = apparent_energy_accumulator[23] && !q.va_msb;
      d.va_msb = apparent_energy_accumulator[23];
      ev[FLG_VA_OVF] = apparent_energy_overflow;
      d.div_cnt = tick ? 12'h000 : q.div_cnt + 12'h001;
      if (zero_cross) begin
         d.zx_cnt = 12'h000;
         d.zx_fired = 1'b0;
      end else if (tick && !q.zx_fired && (q.zx_limit != 12'h000)) begin
         d.zx_cnt = q.zx_cnt + 12'h001;
         if (q.zx_cnt + 12'h001 == q.zx_limit) begin
            ev[FLG_ZERO_CROSS_TIMEOUT_FLAG] = 1'b1;
            d.zx_fired = 1'b1;
         end
      end
      if (power_valid) begin
         d.pwr_neg = power_sample[23];
         d.pwr_seen = 1'b1;
         ev[FLG_PWR_POS] = q.pwr_seen && q.pwr_neg && !power_sample[23];
         ev[FLG_PWR_NEG] = q.pwr_seen && !q.pwr_neg && power_sample[23];
      end
      if (ch1_valid) begin
         d.ch1_out = q.channel1_offset_integrator_ctrl[OFS_SIGN] ? (ch1_sample - ofs) : (ch1_sample + ofs);
      end
      // Read data is captured in setup so prdata comes from a flop
      if (setup) begin
         d.rdy = 1'b1;
         d.slverr = !hit;
         d.prdata = (pwrite || !hit) ? 32'h00000000 : rdval;
         d.rc = hit && !pwrite && (idx == IDX_IRQ_STATUS_RC);
      end
      if (done) begin
         d.rdy = 1'b0;
         d.rc = 1'b0;
         if (q.rc) begin
            clr = q.prdata[15:8];
         end
         if (pwrite && hit) begin
            unique case (idx)
               IDX_IRQ_ENABLE: d.enable = pwdata[15:8] & FLAG_MASK;
               IDX_IRQ_STATUS: clr = clr | pwdata[15:8];
               IDX_CH1_OFFSET_CTRL: d.channel1_offset_integrator_ctrl = pwdata[7:0] & CHANNEL1_OFFSET_INTEGRATOR_CTRL_WMASK;
               IDX_VPEAK_THRESHOLD: d.vpk_thr = pwdata[15:0];
               IDX_IPEAK_THRESHOLD: d.ipk_thr = pwdata[15:0];
               IDX_ZERO_CROSS_TIMEOUT_FLAG_LIMIT: d.zx_limit = pwdata[11:0];
               default: d.enable = q.enable;
            endcase
         end
      end
      // Clear-on-read clears only the flags the host saw, a status write the flags written as one; a new event in the same cycle wins
      d.status = ((q.status & ~clr) | ev) & FLAG_MASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{status: RST_STATUS, enable: RST_ENABLE, channel1_offset_integrator_ctrl: RST_CHANNEL1_OFFSET_INTEGRATOR_CTRL,
            vpk_thr: RST_VPEAK_THR, ipk_thr: RST_IPEAK_THR, zx_limit: RST_ZERO_CROSS_TIMEOUT_FLAG_LIMIT,
            default: '0};
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = psel && penable && q.rdy;
   assign pslverr = done && q.slverr;
   assign ch1_corrected = q.ch1_out;
   assign ch1_offset_mag = q.channel1_offset_integrator_ctrl[OFS_MAG_MSB:0];
   assign ch1_offset_neg = q.channel1_offset_integrator_ctrl[OFS_SIGN];
   assign ch1_integrator_en = q.channel1_offset_integrator_ctrl[OFS_INTEGRATOR];
   // active-low interrupt; the host is left to read status first
   assign irq_oe = |(q.status & q.enable);
   assign irq_n = !irq_oe;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_vpeak_sets_flag: assert property (
      ch2_valid && (mag2[23:8] > q.vpk_thr) |=> q.status[FLG_VPEAK])
      else $error("voltage peak flag not set");

   chk_ipeak_sets_flag: assert property (
      ch1_valid && (mag1[23:8] > q.ipk_thr) |=> q.status[FLG_IPEAK])
      else $error("current peak flag not set");

   chk_half_full_edge: assert property (
      $rose(apparent_energy_accumulator[23]) |-> ##1 q.status[FLG_VA_HALF])
      else $error("half full flag missed msb rise");

   chk_ovf_sets_flag: assert property (
      apparent_energy_overflow |=> q.status[FLG_VA_OVF])
      else $error("overflow flag not set");

   chk_zero_cross_timeout_flag_cause: assert property (
      $rose(q.status[FLG_ZERO_CROSS_TIMEOUT_FLAG]) |-> $past(tick) && !$past(zero_cross))
      else $error("zero cross timeout flag without timeout");

   // Keyed on the remembered sign so widely spaced samples are covered too
   chk_power_rise: assert property (
      power_valid && !power_sample[23] && q.pwr_seen && q.pwr_neg
      |=> q.status[FLG_PWR_POS])
      else $error("power positive flag not set");

   chk_power_fall: assert property (
      power_valid && power_sample[23] && q.pwr_seen && !q.pwr_neg
      |=> q.status[FLG_PWR_NEG])
      else $error("power negative flag not set");

   chk_ofs_readback: assert property (
      done && pwrite && (idx == IDX_CH1_OFFSET_CTRL) && (paddr[1:0] == 2'h0)
      |=> q.channel1_offset_integrator_ctrl == (($past(pwdata) & 32'h000000BF) & 32'h000000FF))
      else $error("offset control write lost");

   chk_ofs_apply: assert property (
      ch1_valid |=> ch1_corrected == ($past(q.channel1_offset_integrator_ctrl[OFS_SIGN])
         ? $past(ch1_sample) - {19'h00000, $past(q.channel1_offset_integrator_ctrl[4:0])}
         : $past(ch1_sample) + {19'h00000, $past(q.channel1_offset_integrator_ctrl[4:0])}))
      else $error("offset correction wrong");

   chk_irq_follows: assert property (
      done && pwrite && (idx == IDX_IRQ_ENABLE) && |(q.status & pwdata[15:8] & 8'h7F)
      |=> !irq_n ##0 irq_oe)
      else $error("interrupt not raised for enabled flag");

   chk_reserved_zero: assert property (
      done && !pwrite |-> !prdata[15] && !(idx == IDX_CH1_OFFSET_CTRL && prdata[6]))
      else $error("reserved bit read nonzero");

   chk_rc_clears: assert property (
      done && q.rc && !apparent_energy_overflow |=> !q.status[FLG_VA_OVF]
      || !$past(q.prdata[FLAG_LSB + FLG_VA_OVF]))
      else $error("clear on read left flag set");

   chk_vpeak_sticky: assert property (
      q.status[FLG_VPEAK] && !done |=> q.status[FLG_VPEAK])
      else $error("voltage peak flag dropped without access");

   chk_w1c_ovf: assert property (
      done && pwrite && hit && (idx == IDX_IRQ_STATUS) && pwdata[FLAG_LSB + FLG_VA_OVF]
      && !apparent_energy_overflow |=> !q.status[FLG_VA_OVF])
      else $error("write one left overflow flag set");

   chk_status_top_zero: assert property (
      !q.status[7])
      else $error("reserved status bit set");

   chk_ofs_bit6_zero: assert property (
      !q.channel1_offset_integrator_ctrl[6])
      else $error("unused offset bit set");

   chk_enable_top_zero: assert property (
      !q.enable[7])
      else $error("reserved enable bit set");

   chk_integ_reset: assert property (
      $rose(presetn) |-> !ch1_integrator_en)
      else $error("integrator on after reset");

   chk_ready_first: assert property (
      setup |=> !(psel && penable) || pready)
      else $error("access phase without ready");

   chk_err_no_write: assert property (
      done && pwrite && !hit |=> $stable(q.channel1_offset_integrator_ctrl) && $stable(q.enable))
      else $error("refused write changed a register");

   chk_rc_no_write: assert property (
      done && pwrite && hit && (idx == IDX_IRQ_STATUS_RC) |=> $stable(q.enable) && $stable(q.channel1_offset_integrator_ctrl))
      else $error("write to clear-on-read copy had effect");

   chk_err_flag: assert property (
      done && !hit |-> pslverr)
      else $error("unmapped access without error");

   chk_ok_no_err: assert property (
      done && hit |-> !pslverr)
      else $error("mapped access with error");

   chk_write_rd_zero: assert property (
      done && pwrite |-> prdata == 32'h00000000)
      else $error("write returned read data");

   chk_zero_cross_timeout_flag_limit: assert property (
      $rose(q.status[FLG_ZERO_CROSS_TIMEOUT_FLAG]) |-> $past(q.zx_limit) != 12'h000)
      else $error("timeout with limit zero");

   chk_pos_cause: assert property (
      $rose(q.status[FLG_PWR_POS]) |-> $past(power_valid) && !$past(power_sample[23]))
      else $error("power positive flag without sample");

   chk_neg_cause: assert property (
      $rose(q.status[FLG_PWR_NEG]) |-> $past(power_valid) && $past(power_sample[23]))
      else $error("power negative flag without sample");

   chk_half_cause: assert property (
      $rose(q.status[FLG_VA_HALF]) |-> $past(apparent_energy_accumulator[23]))
      else $error("half full flag without msb");

   chk_ovf_cause: assert property (
      $rose(q.status[FLG_VA_OVF]) |-> $past(apparent_energy_overflow))
      else $error("overflow flag without pulse");

   chk_vpeak_cause: assert property (
      $rose(q.status[FLG_VPEAK]) |-> $past(ch2_valid))
      else $error("voltage peak flag without sample");

   chk_ipeak_cause: assert property (
      $rose(q.status[FLG_IPEAK]) |-> $past(ch1_valid))
      else $error("current peak flag without sample");

   chk_sign_write: assert property (
      done && pwrite && hit && (idx == IDX_CH1_OFFSET_CTRL) |=> ch1_offset_neg == $past(pwdata[5]))
      else $error("offset sign pin wrong");

   chk_mag_write: assert property (
      done && pwrite && hit && (idx == IDX_CH1_OFFSET_CTRL) |=> ch1_offset_mag == $past(pwdata[4:0]))
      else $error("offset magnitude pins wrong");

   chk_integ_write: assert property (
      done && pwrite && hit && (idx == IDX_CH1_OFFSET_CTRL)
      |=> ch1_integrator_en == $past(pwdata[7]))
      else $error("integrator pin wrong");

   // Pin must be released whenever nothing enabled is pending
   chk_irq_idle: assert property (
      !(|(q.status & q.enable)) |-> irq_n && !irq_oe)
      else $error("interrupt driven with nothing enabled");

   cov_rc_read: cover property (done && q.rc && (q.prdata[15:8] != 8'h00));
   cov_zero_cross_timeout_flag: cover property ($rose(q.status[FLG_ZERO_CROSS_TIMEOUT_FLAG]));
   cov_irq: cover property ($fell(irq_n));
   cov_set_and_clear: cover property (done && q.rc && |(q.prdata[15:8] & ev));

endmodule

// ===== mif_host.sv
// Purpose: APB host model standing in for the metering microcontroller
// Assumes: The slave ends each access with pready
// Notes: Waits are unbounded here; the bench timeout cuts a hang short
`timescale 1ns/1ps
module mif_host (
   input wire logic pclk, // Bus clock
   output logic psel, // Select
   output logic penable, // Access phase
   output logic pwrite, // Write when high
   output logic [7:0] paddr, // Byte address
   output logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Transfer done
   input wire logic pslverr // Transfer refused
);
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Stale data is inverted so nobody can lean on it after release
      pwdata <= ~d;
   endtask
endmodule

// ===== mif_regs_test.sv
// Purpose: Self-checking bench for the flag and offset register block
// Assumes: Host model drives APB; events are driven here on pclk
// Notes: Random offsets and samples come from seed 50
`timescale 1ns/1ps
module mif_regs_test;
   import mif_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr, neg, integ, irq_n, irq_oe, err;
   logic [7:0] paddr, v;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] s1 = 24'h0, s2 = 24'h0, acc = 24'h0, pw = 24'h0, cor;
   logic v1 = 1'h0, v2 = 1'h0, ovf = 1'h0, zx = 1'h0, pv = 1'h0;
   logic [4:0] mag;
   int fails = 0, n_checks = 0, cyc = 0;
   always #25 pclk = ~pclk;
   mif_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   mif_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ch1_sample(s1), .ch1_valid(v1), .ch2_sample(s2), .ch2_valid(v2),
      .apparent_energy_accumulator(acc), .apparent_energy_overflow(ovf), .zero_cross(zx),
      .power_sample(pw), .power_valid(pv), .ch1_corrected(cor), .ch1_offset_mag(mag),
      .ch1_offset_neg(neg), .ch1_integrator_en(integ), .irq_n(irq_n), .irq_oe(irq_oe));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rw(input logic w, input logic [5:0] i, input logic [31:0] d);
      u_host.xfer(w, {i, 2'h0}, d, rd, err);
   endtask
   // One event per call; 7 primes the power sign with a negative sample
   task automatic ev(input int i);
      @(posedge pclk);
      case (i)
         0: begin s2 <= 24'h001100; v2 <= 1'h1; end
         1: begin s1 <= 24'h001100; v1 <= 1'h1; end
         2: acc <= 24'h800000;
         3: ovf <= 1'h1;
         4: zx <= 1'h1;
         default: begin pw <= (i == 5) ? 24'h000004 : 24'hFFFFFC; pv <= 1'h1; end
      endcase
      @(posedge pclk);
      {v1, v2, ovf, pv, zx} <= 5'h00;
      acc <= 24'h0;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(50));
      repeat (3) @(posedge pclk);
      #10 presetn = 1'h1;
      rw(0, IDX_CH1_OFFSET_CTRL, 32'h0);
      chk("ofs_rst", 32'h0, rd);
      chk("irq_rst", 32'h1, {irq_oe, irq_n});
      $display("reset test done");
      for (int k = 0; k < 5; k++) begin
         v = (k == 0) ? 8'hFF : 8'($urandom);
         rw(1, IDX_CH1_OFFSET_CTRL, {24'h0, v});
         rw(0, IDX_CH1_OFFSET_CTRL, 32'h0);
         chk("ofs_rd", {24'h0, v & 8'hBF}, rd);
         chk("ofs_pins", {v[7], v[5:0]}, {integ, neg, mag});
         s1 <= 24'($urandom);
         v1 <= 1'h1;
         @(posedge pclk);
         v1 <= 1'h0;
         #1 chk("cor", v[5] ? 24'(s1 - v[4:0]) : 24'(s1 + v[4:0]), cor);
      end
      $display("offset test done");
      rw(1, IDX_IRQ_ENABLE, 32'hFFFFFFFF);
      rw(0, IDX_IRQ_ENABLE, 32'h0);
      chk("en_rd", 32'h7F00, rd);
      rw(1, IDX_VPEAK_THRESHOLD, 32'h10);
      rw(1, IDX_IPEAK_THRESHOLD, 32'h10);
      ev(7);
      for (int i = 0; i < 7; i++) begin
         if (i == 4)
            rw(1, IDX_ZERO_CROSS_TIMEOUT_FLAG_LIMIT, 32'h2);
         ev(i);
         if (i == 4)
            repeat (2 * ZERO_CROSS_TIMEOUT_FLAG_TICK_CYCLES + 4) @(posedge pclk);
         #1 chk("irq", 32'h0, irq_n);
         rw(0, IDX_IRQ_STATUS, 32'h0);
         chk("flag", 32'h100 << i, rd);
         rw(1, IDX_IRQ_STATUS, 32'hFFFFFFFF);
         rw(0, IDX_IRQ_STATUS, 32'h0);
         chk("w1c", 32'h0, rd);
      end
      $display("event test done");
      rw(1, IDX_IRQ_ENABLE, 32'h0);
      ev(3);
      #1 chk("masked", 32'h1, irq_n);
      rw(1, IDX_IRQ_ENABLE, 32'h0800);
      #1 chk("unmasked", 32'h0, irq_n);
      rw(0, IDX_IRQ_STATUS_RC, 32'h0);
      chk("rc", 32'h0800, rd);
      #1 chk("rc_irq", 32'h1, irq_n);
      rw(0, IDX_IRQ_STATUS, 32'h0);
      chk("rc_clr", 32'h0, rd);
      $display("mask test done");
      u_host.xfer(1'h0, 8'hFC, 32'h0, rd, err);
      chk("unmapped", 32'h1, err);
      u_host.xfer(1'h1, 8'h35, 32'hFF, rd, err);
      chk("misalign", 32'h1, err);
      $display("error test done");
      report_and_stop();
   end
endmodule
